/* File: logic/wwd_top.sv */
/*
  windowed watchdog with AHB-Lite register slave.
  assumes the protection-key logic drives ccpUnlock high during the
  four-instruction window, and fuseConfig is stable at reset release.
*/
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module wwd_top
  import wwd_pkg::*;
#(
  parameter int unsigned TICK_DIVIDE = TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] fuseConfig,
  input wire logic ccpUnlock,
  input wire logic restartReq,
  input wire logic debugHalt,
  output logic systemReset
);

  // ==========================================================
  // helpers
  function automatic logic codeValid(input logic [3:0] code);
    codeValid = (code != CODE_OFF) && (code <= CODE_MAX);
  endfunction : codeValid

  function automatic logic [PERIOD_CNT_W-1:0] codeTicks(input logic [3:0] code);
    codeTicks = BASE_TICKS << (code - 4'h1);
  endfunction : codeTicks

  // ==========================================================
  // tick divider: one-cycle enable at 1 kHz
  logic [TICK_CNT_W-1:0] tickCount;
  logic tick;
  wire tickWrap = (tickCount == TICK_CNT_W'(TICK_DIVIDE - 1));

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tickCount <= '0;
      tick <= 1'b0;
    end
    else
    begin
      // free-running in every sleep state, never gated by the core
      tickCount <= tickWrap ? '0 : tickCount + 1'b1;
      tick <= tickWrap;
    end
  end

  // ==========================================================
  // bus address phase capture
  logic phaseValid;
  logic phaseWrite;
  logic [ADDR_W-1:0] phaseIndex;
  wire addrPhase = hsel && hready && htrans[1];
  wire wordAligned = (haddr[1:0] == 2'b00);
  wire [ADDR_W-1:0] reqIndex = haddr[ADDR_W+1:2];
  wire inRange = (haddr[31:ADDR_W+2] == '0) && wordAligned;
  wire hitControl = inRange && (reqIndex == CONTROL_INDEX);
  wire hitState = inRange && (reqIndex == STATE_INDEX);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phaseValid <= 1'b0;
      phaseWrite <= 1'b0;
      phaseIndex <= '0;
    end
    else
    begin
      phaseValid <= addrPhase && inRange;
      phaseWrite <= hwrite;
      phaseIndex <= reqIndex;
    end
  end

  wire writeControl = phaseValid && phaseWrite && (phaseIndex == CONTROL_INDEX);
  wire writeState = phaseValid && phaseWrite && (phaseIndex == STATE_INDEX);

  // ==========================================================
  // control, lock and boot load
  logic bootPending;
  logic [7:0] control;
  logic lock;
  logic sync_busy_flag;
  logic [1:0] ctrlSyncTicks;

  // writes outside the key window are taken on the bus and dropped
  wire ctrlAccept = writeControl && ccpUnlock && !lock && !sync_busy_flag;
  wire lockSet = writeState && ccpUnlock && hwdata[LOCK_BIT];
  wire lockClear = writeState && ccpUnlock && !hwdata[LOCK_BIT] && debugHalt;
  wire ctrlLanded = sync_busy_flag && tick && (ctrlSyncTicks == CONTROL_SYNC_TICKS - 2'h1);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bootPending <= 1'b1;
      control <= '0;
      lock <= STATE_RESET[LOCK_BIT];
      sync_busy_flag <= STATE_RESET[BUSY_BIT];
      ctrlSyncTicks <= '0;
    end
    else if (bootPending)
    begin
      // fuse caught one cycle after release, not in the reset branch
      bootPending <= 1'b0;
      control <= fuseConfig;
      lock <= (fuseConfig[PERIOD_MSB:PERIOD_LSB] != CODE_OFF);
      sync_busy_flag <= 1'b1;
      ctrlSyncTicks <= '0;
    end
    else
    begin
      if (ctrlAccept)
      begin
        control <= hwdata[7:0];
      end
      if (lockSet)
      begin
        lock <= 1'b1;
      end
      else if (lockClear)
      begin
        lock <= 1'b0;
      end
      if (ctrlAccept)
      begin
        sync_busy_flag <= 1'b1;
        ctrlSyncTicks <= '0;
      end
      else if (ctrlLanded)
      begin
        sync_busy_flag <= 1'b0;
      end
      else if (sync_busy_flag && tick)
      begin
        ctrlSyncTicks <= ctrlSyncTicks + 2'h1;
      end
    end
  end

  // ==========================================================
  // watchdog-domain configuration, taken when the crossing lands
  logic [7:0] activeCfg;
  wire [3:0] openCode = activeCfg[PERIOD_MSB:PERIOD_LSB];
  wire [3:0] closedCode = activeCfg[WINDOW_MSB:WINDOW_LSB];
  wire windowReserved = (closedCode > CODE_MAX);
  wire wdEnabled = codeValid(openCode) && !windowReserved;
  wire windowMode = codeValid(closedCode);
  wire [PERIOD_CNT_W-1:0] openTicks = codeTicks(openCode);
  wire [PERIOD_CNT_W-1:0] closedTicks = codeTicks(closedCode);

  // ==========================================================
  // restart synchroniser
  logic restartPending;
  logic [1:0] restartTicks;
  logic restartReqLast;
  // a held request counts once; last value resets to the idle level, so no false edge
  wire restartEdge = restartReq && !restartReqLast;
  wire restartLanded = restartPending && tick && (restartTicks == RESTART_SYNC_TICKS - 2'h1);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      restartReqLast <= 1'b0;
    end
    else
    begin
      restartReqLast <= restartReq;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      restartPending <= 1'b0;
      restartTicks <= '0;
    end
    else if (!restartPending)
    begin
      restartPending <= restartEdge;
      restartTicks <= '0;
    end
    else if (restartLanded)
    begin
      restartPending <= 1'b0;
    end
    else if (tick)
    begin
      // further requests are dropped until this one lands
      restartTicks <= restartTicks + 2'h1;
    end
  end

  // ==========================================================
  // sequencer
  wwd_state_e state;
  wwd_state_e next_state;
  logic [PERIOD_CNT_W-1:0] periodCount;
  logic [PERIOD_CNT_W-1:0] next_periodCount;
  logic next_systemReset;
  logic debugSeen;

  wire debugExit = debugSeen && !debugHalt;
  wire openExpire = tick && (periodCount >= openTicks - 1'b1);
  wire closedExpire = tick && (periodCount >= closedTicks - 1'b1);

  always_comb
  begin
    next_state = state;
    next_periodCount = periodCount;
    next_systemReset = 1'b0;
    if (debugHalt)
    begin
      next_state = WWD_IDLE;
      next_periodCount = '0;
    end
    else if (debugExit)
    begin
      // closed period skipped after debug, one normal time-out runs
      next_state = wdEnabled ? WWD_OPEN : WWD_IDLE;
      next_periodCount = '0;
    end
    else if (ctrlLanded || bootPending)
    begin
      next_periodCount = '0;
      next_state = WWD_IDLE;
    end
    else if (!wdEnabled)
    begin
      next_state = WWD_IDLE;
      next_periodCount = '0;
    end
    else
    begin
      case (state)
        WWD_IDLE:
        begin
          // freshly enabled configuration
          next_state = windowMode ? WWD_ARMED : WWD_OPEN;
          next_periodCount = '0;
        end
        WWD_ARMED:
        begin
          if (restartLanded)
          begin
            next_state = WWD_CLOSED;
            next_periodCount = '0;
          end
        end
        WWD_CLOSED:
        begin
          if (restartLanded)
          begin
            next_systemReset = 1'b1;
            next_state = WWD_ARMED;
            next_periodCount = '0;
          end
          else if (closedExpire)
          begin
            next_state = WWD_OPEN;
            next_periodCount = '0;
          end
          else if (tick)
          begin
            next_periodCount = periodCount + 1'b1;
          end
        end
        WWD_OPEN:
        begin
          if (restartLanded)
          begin
            next_state = windowMode ? WWD_CLOSED : WWD_OPEN;
            next_periodCount = '0;
          end
          else if (openExpire)
          begin
            next_systemReset = 1'b1;
            next_state = windowMode ? WWD_ARMED : WWD_OPEN;
            next_periodCount = '0;
          end
          else if (tick)
          begin
            next_periodCount = periodCount + 1'b1;
          end
        end
        default:
        begin
          next_state = WWD_IDLE;
          next_periodCount = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= WWD_IDLE;
      periodCount <= '0;
      systemReset <= 1'b0;
      debugSeen <= 1'b0;
      activeCfg <= '0;
    end
    else
    begin
      state <= next_state;
      periodCount <= next_periodCount;
      systemReset <= next_systemReset;
      debugSeen <= debugHalt;
      if (ctrlLanded)
      begin
        activeCfg <= control;
      end
    end
  end

  // ==========================================================
  // read data and response, zero wait states, always OKAY
  wire [7:0] stateView = {lock, 6'b00_0000, sync_busy_flag};
  wire [31:0] readMux = hitControl ? {24'h00_0000, control} :
    hitState ? {24'h00_0000, stateView} : 32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hrdata <= (addrPhase && !hwrite) ? readMux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule : wwd_top

/* File: logic/wwd_pkg.sv */
/*
  constants, register map and state encoding for the windowed watchdog.
  assumes a 250 MHz system clock and a 1 kHz watchdog tick made from it.
*/
package wwd_pkg;

  // ==========================================================
  // clocking
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TICK_HZ = 1_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int TICK_CNT_W = 18;

  // ==========================================================
  // register map: printed indices, byte address is four times index
  localparam logic [7:0] CONTROL_INDEX = 8'h00;
  localparam logic [7:0] STATE_INDEX = 8'h01;
  localparam int ADDR_W = 8;

  // control fields
  localparam int WINDOW_MSB = 7;
  localparam int WINDOW_LSB = 4;
  localparam int PERIOD_MSB = 3;
  localparam int PERIOD_LSB = 0;
  // state fields
  localparam int LOCK_BIT = 7;
  localparam int BUSY_BIT = 0;
  localparam logic [7:0] STATE_RESET = 8'h00;

  // ==========================================================
  // timing codes
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hB;
  localparam int PERIOD_CNT_W = 14;
  localparam logic [13:0] BASE_TICKS = 14'h0008;

  // restart crosses on its third tick, control on its second
  localparam logic [1:0] RESTART_SYNC_TICKS = 2'h3;
  localparam logic [1:0] CONTROL_SYNC_TICKS = 2'h2;

  // ==========================================================
  // watchdog sequencer, gray along idle, armed, closed, open
  typedef enum logic [1:0]
  {
    WWD_IDLE = 2'b00,
    WWD_ARMED = 2'b01,
    WWD_CLOSED = 2'b11,
    WWD_OPEN = 2'b10
  } wwd_state_e;

endpackage : wwd_pkg

/* File: verification/wwd_chk.sv */
/*
  port checker for the windowed watchdog, bound to wwd_top.
  assumes the top's clk and its synchronous active-high reset.
*/
`timescale 1ns/100ps
module wwd_chk
  import wwd_pkg::*;
#(
  parameter int unsigned TICK_DIVIDE = TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic debugHalt,
  input wire logic systemReset
);
  // ==========================================
  // helpers
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic readPhase;
  logic [31:0] readAddr;
  int unsigned gap;
  wire logic readNow = hsel && hready && htrans[1] && !hwrite;
  // gap restarts at reset so the first pulse is judged from release
  always_ff @(posedge clk)
  begin
    readPhase <= !reset && readNow;
    readAddr <= haddr;
    gap <= (reset || systemReset) ? '0 : gap + 32'h0000_0001;
  end
  sequence halted3;
    debugHalt [*3];
  endsequence
  // ==========================================
  // assertions
  AST_READY: assert property (hreadyout)
    else $error("slave not ready");
  AST_OKAY: assert property (!hresp)
    else $error("slave answered with error");
  AST_PULSE: assert property (systemReset |=> !systemReset)
    else $error("system reset longer than one cycle");
  AST_GAP: assert property (systemReset |-> gap >= 2 * TICK_DIVIDE)
    else $error("system resets too close together");
  AST_HALT: assert property (halted3 |-> !systemReset)
    else $error("system reset while halted");
  AST_IDLE: assert property (!readPhase |-> hrdata == '0)
    else $error("read data outside data phase");
  AST_WIDTH: assert property (hrdata[31:8] == '0)
    else $error("upper read bits not zero");
  AST_STATE: assert property (readPhase && readAddr == 32'h0000_0004 |-> hrdata[6:1] == '0)
    else $error("unused state bits not zero");
  AST_HOLE: assert property (readPhase && (readAddr > 32'h0000_0004 || readAddr[1:0] != 2'h0) |-> hrdata == '0)
    else $error("unmapped read not zero");
endmodule : wwd_chk
bind wwd_top wwd_chk #(.TICK_DIVIDE(TICK_DIVIDE)) wwd_chk_i
(
  .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .debugHalt, .systemReset
);

/* File: verification/wwd_cpu.sv */
/*
  cpu model: bus master, protection-key window and restart pulses.
  assumes a single slave whose hreadyout is the bus hready.
*/
`timescale 1ns/100ps
module wwd_cpu
(
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel = 1'h0,
  output logic [31:0] haddr = 32'h0000_0000,
  output logic [1:0] htrans = 2'h0,
  output logic hwrite = 1'h0,
  output logic [2:0] hsize = 3'h2,
  output logic [31:0] hwdata = 32'h0000_0000,
  output logic ccpUnlock = 1'h0,
  output logic restartReq = 1'h0
);
  // ==========================================
  // key window spans only this one access
  task xfer(input logic w, input logic k, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    ccpUnlock <= k;
    @(posedge clk);
    while (!hready) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hready) @(posedge clk);
    q = hrdata;
    hsel <= 1'h0;
    ccpUnlock <= 1'h0;
    hwdata <= ~d;
    // one idle edge, so a following call never re-drives these in the same step
    @(posedge clk);
  endtask : xfer
  task kick;
    restartReq <= 1'h1;
    @(posedge clk);
    restartReq <= 1'h0;
  endtask : kick
endmodule : wwd_cpu

/* File: verification/tb_windowed_watchdog_timer.sv */
/*
  testbench for the windowed watchdog driven through the cpu model.
  assumes a four-clock tick so every period the scenarios program fits the run.
*/
`timescale 1ns/100ps
module tb_windowed_watchdog_timer;
  import wwd_pkg::*;
  localparam int D = 4;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic debugHalt = 1'h0;
  logic [7:0] fuseConfig = 8'h00;
  logic hsel, hwrite, hreadyout, hresp, ccpUnlock, restartReq, systemReset;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  wwd_top #(.TICK_DIVIDE(D)) wwd_top_i
  (
    .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .fuseConfig, .ccpUnlock, .restartReq, .debugHalt, .systemReset
  );
  wwd_cpu wwd_cpu_i
  (
    .clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .ccpUnlock, .restartReq
  );
  // ==========================================
  // shared tasks
  task tally_and_finish;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wwd_cpu_i.xfer(1'h0, 1'h0, {24'h00_0000, a}, 32'h0000_0000, q);
    chk("register", q, {24'h00_0000, e});
  endtask : rc
  task wr(input logic [7:0] a, input logic [7:0] d, input logic k);
    logic [31:0] q;
    wwd_cpu_i.xfer(1'h1, k, {24'h00_0000, a}, {24'h00_0000, d}, q);
  endtask : wr
  // first pulse must land in [lo, hi) when e, none within hi cycles otherwise
  task watch(input int lo, input int hi, input logic e);
    int p;
    p = -1;
    for (int n = 0; n < hi && !(e && p >= 0); n++)
    begin
      @(posedge clk);
      if (systemReset === 1'h1 && p < 0)
        p = n;
    end
    chk("system reset", e ? p >= lo : p >= 0, e);
  endtask : watch
  task boot(input logic [7:0] f);
    reset <= 1'h1;
    fuseConfig <= f;
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
  endtask : boot
  // ==========================================
  // scenarios
  task t_fuse;
    boot(8'h01);
    rc(8'h04, 8'h81);
    repeat (3 * D) @(posedge clk);
    rc(8'h04, 8'h80);
    watch(0, 20 * D, 1'h1);
    watch(7 * D, 10 * D, 1'h1);
    for (int i = 0; i < 4; i++)
    begin
      wwd_cpu_i.kick();
      watch(0, 5 * D, 1'h0);
    end
    wr(8'h00, 8'h00, 1'h1);
    rc(8'h00, 8'h01);
    wr(8'h04, 8'h00, 1'h1);
    rc(8'h04, 8'h80);
  endtask : t_fuse
  task t_debug;
    debugHalt <= 1'h1;
    watch(0, 20 * D, 1'h0);
    wr(8'h04, 8'h00, 1'h1);
    rc(8'h04, 8'h00);
    wr(8'h00, 8'h00, 1'h1);
    repeat (3 * D) @(posedge clk);
    rc(8'h00, 8'h00);
    debugHalt <= 1'h0;
    watch(0, 20 * D, 1'h0);
    wr(8'h00, 8'h0C, 1'h1);
    watch(0, 20 * D, 1'h0);
    wr(8'h00, 8'h11, 1'h0);
    rc(8'h00, 8'h0C);
    wr(8'h00, 8'hC1, 1'h1);
    watch(0, 20 * D, 1'h0);
    rc(8'h08, 8'h00);
    rc(8'h06, 8'h00);
  endtask : t_debug
  task t_window;
    boot(8'h00);
    rc(8'h04, 8'h01);
    repeat (3 * D) @(posedge clk);
    wr(8'h04, 8'h80, 1'h0);
    rc(8'h04, 8'h00);
    wr(8'h00, 8'h11, 1'h1);
    rc(8'h04, 8'h01);
    watch(0, 20 * D, 1'h0);
    wwd_cpu_i.kick();
    repeat (D) @(posedge clk);
    wwd_cpu_i.kick();
    watch(0, 10 * D, 1'h0);
    wwd_cpu_i.kick();
    watch(11 * D, 22 * D, 1'h1);
    wwd_cpu_i.kick();
    repeat (4 * D) @(posedge clk);
    wwd_cpu_i.kick();
    watch(D, 6 * D, 1'h1);
    debugHalt <= 1'h1;
    repeat (8) @(posedge clk);
    debugHalt <= 1'h0;
    watch(6 * D, 12 * D, 1'h1);
    wr(8'h04, 8'h80, 1'h1);
    rc(8'h04, 8'h80);
    wr(8'h00, 8'h00, 1'h1);
    rc(8'h00, 8'h11);
  endtask : t_window
  initial
  begin
    t_fuse();
    t_debug();
    t_window();
    tally_and_finish();
  end
endmodule : tb_windowed_watchdog_timer
